/* File: pieb_pkg.sv */
// Functional notes
// - No peripheral request without peripheral gate set
// - Flags set on events, ignoring any enable
// - Enable bit 1: serial two collision
// - Enable bit 0: serial two transfer
// - Unimplemented bits read zero, ignore writes
// - Flag reads one while pending
// - All implemented bits reset to zero
// - Flags1: gate bit7, timer2 bit1, overflow bit0
// - Flags1: converter bit6, serial bit3, capture bit2
// - Flags1: uart bits 5,4, read-only
// - Flags2 bit7: oscillator failure flag
// - Flags2: comparator two bit6, one bit5
// - Flags2: eeprom bit4, serial collision bit3
// - Flags2 bit0 capture two; bits 2,1 absent
// - Flags3: capture four bit5, three bit4
// - Flags3: timer six bit3, timer four bit1
`default_nettype none

package pieb_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int PIEB_ADDR_W = 8;
    localparam int PIEB_DATA_W = 32;
    localparam int PIEB_REG_W = 8;
    localparam logic [1:0] PIEB_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIEB_RESP_DECERR = 2'h3;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_CORE_CTRL = 8'h00;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_ENABLE_1 = 8'h04;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_ENABLE_2 = 8'h08;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_ENABLE_3 = 8'h0c;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_SERIAL_TWO_EN = 8'h10;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_FLAGS_1 = 8'h14;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_FLAGS_2 = 8'h18;
    localparam logic [PIEB_ADDR_W-1:0] PIEB_ADDR_FLAGS_3 = 8'h1c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PIEB_BIT_GLOBAL_GATE = 7;
    localparam int PIEB_BIT_PERIPH_GATE = 6;
    localparam int PIEB_BIT_S2_COLLISION = 1;
    localparam int PIEB_BIT_S2_TRANSFER = 0;
    // Flags 1
    localparam int PIEB_BIT_TIMER_ONE_GATE = 7;
    localparam int PIEB_BIT_CONVERTER_DONE = 6;
    localparam int PIEB_BIT_UART_RECEIVE = 5;
    localparam int PIEB_BIT_UART_TRANSMIT = 4;
    localparam int PIEB_BIT_SERIAL_ONE = 3;
    localparam int PIEB_BIT_CAPTURE_ONE = 2;
    localparam int PIEB_BIT_TIMER_TWO = 1;
    localparam int PIEB_BIT_TIMER_ONE_OVF = 0;
    // Flags 2
    localparam int PIEB_BIT_OSC_FAIL = 7;
    localparam int PIEB_BIT_COMPARATOR_TWO = 6;
    localparam int PIEB_BIT_COMPARATOR_ONE = 5;
    localparam int PIEB_BIT_EEPROM_DONE = 4;
    localparam int PIEB_BIT_SERIAL_ONE_COLL = 3;
    localparam int PIEB_BIT_CAPTURE_TWO = 0;
    // Flags 3
    localparam int PIEB_BIT_CAPTURE_FOUR = 5;
    localparam int PIEB_BIT_CAPTURE_THREE = 4;
    localparam int PIEB_BIT_TIMER_SIX = 3;
    localparam int PIEB_BIT_TIMER_FOUR = 1;

    // ****************************************
    // Implemented-bit masks and reset values
    // ****************************************
    localparam logic [PIEB_REG_W-1:0] PIEB_MASK_CORE_CTRL = 8'hc0;
    localparam logic [PIEB_REG_W-1:0] PIEB_MASK_ENABLE_1 = 8'hff;
    localparam logic [PIEB_REG_W-1:0] PIEB_MASK_ENABLE_2 = 8'hf9;
    localparam logic [PIEB_REG_W-1:0] PIEB_MASK_ENABLE_3 = 8'h3a;
    localparam logic [PIEB_REG_W-1:0] PIEB_MASK_SERIAL_TWO_EN = 8'h03;
    localparam logic [PIEB_REG_W-1:0] PIEB_SW_MASK_FLAGS_1 = 8'hcf;
    localparam logic [PIEB_REG_W-1:0] PIEB_HW_MASK_FLAGS_1 = 8'h30;
    localparam logic [PIEB_REG_W-1:0] PIEB_SW_MASK_FLAGS_2 = 8'hf9;
    localparam logic [PIEB_REG_W-1:0] PIEB_SW_MASK_FLAGS_3 = 8'h3a;
    localparam logic [PIEB_REG_W-1:0] PIEB_HW_MASK_NONE = 8'h00;
    localparam logic [PIEB_REG_W-1:0] PIEB_REG_RESET = 8'h00;

    // ****************************************
    // Bus state machines
    // ****************************************
    typedef enum logic [1:0] {
        PIEB_WR_IDLE = 2'b01,
        PIEB_WR_RESP = 2'b10
    } pieb_wr_e;

    typedef enum logic [1:0] {
        PIEB_RD_IDLE = 2'b01,
        PIEB_RD_DATA = 2'b10
    } pieb_rd_e;

endpackage : pieb_pkg

`default_nettype wire

/* File: pieb_flag_bank.sv */
`default_nettype none

module pieb_flag_bank
    import pieb_pkg::*;
#(
    parameter int WIDTH = PIEB_REG_W,
    parameter logic [WIDTH-1:0] SW_MASK = '0,
    parameter logic [WIDTH-1:0] HW_MASK = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Hardware side
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] hw_level,
    // Software write
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // Flag values
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pieb_fb_s;

    pieb_fb_s st_r;
    pieb_fb_s st_nxt;
    logic [WIDTH-1:0] bit_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            if (SW_MASK[gi]) begin : g_sw
                // Set beats a clear landing in the same cycle
                assign bit_nxt[gi] = set_pulse[gi] | (wr_en ? wr_data[gi] : st_r.flags[gi]);
            end else if (HW_MASK[gi]) begin : g_hw
                assign bit_nxt[gi] = hw_level[gi];
            end else begin : g_none
                assign bit_nxt[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        st_nxt.flags = bit_nxt;
        if (!aresetn) begin
            st_nxt.flags = '0;
        end
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    assign flags = st_r.flags;

endmodule : pieb_flag_bank

`default_nettype wire

/* File: pieb_irq_bank.sv */
`default_nettype none

module pieb_irq_bank
    import pieb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [PIEB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [PIEB_DATA_W-1:0] s_axi_wdata,
    input wire logic [PIEB_DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [PIEB_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [PIEB_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral events, first flag register
    input wire logic timer_one_gate_flag_set,
    input wire logic converter_done_flag_set,
    input wire logic uart_receive_pending,
    input wire logic uart_transmit_pending,
    input wire logic serial_one_transfer_flag_set,
    input wire logic capture_unit_one_flag_set,
    input wire logic timer_two_match_flag_set,
    input wire logic timer_one_overflow_flag_set,
    // Peripheral events, second flag register
    input wire logic oscillator_failure_flag_set,
    input wire logic comparator_two_flag_set,
    input wire logic comparator_one_flag_set,
    input wire logic eeprom_write_done_flag_set,
    input wire logic serial_one_collision_flag_set,
    input wire logic capture_unit_two_flag_set,
    // Peripheral events, third flag register
    input wire logic capture_unit_four_flag_set,
    input wire logic capture_unit_three_flag_set,
    input wire logic timer_six_match_flag_set,
    input wire logic timer_four_match_flag_set,
    // Second serial port flag levels, held elsewhere
    input wire logic serial_two_collision_pending,
    input wire logic serial_two_transfer_pending,
    // To core interrupt logic
    output logic peripheral_irq_request,
    output logic global_irq_gate,
    output logic peripheral_irq_gate
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pieb_wr_e wst;
        pieb_rd_e rst;
        logic aw_got;
        logic w_got;
        logic [PIEB_ADDR_W-1:0] awaddr;
        logic [PIEB_REG_W-1:0] wdata;
        logic wlane;
        logic [1:0] bresp;
        logic [PIEB_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [PIEB_REG_W-1:0] core_ctrl;
        logic [PIEB_REG_W-1:0] enable_1;
        logic [PIEB_REG_W-1:0] enable_2;
        logic [PIEB_REG_W-1:0] enable_3;
        logic [PIEB_REG_W-1:0] serial_two_irq_enable;
        logic irq;
    } pieb_state_s;

    pieb_state_s st_r;
    pieb_state_s st_nxt;

    logic [PIEB_REG_W-1:0] set_1;
    logic [PIEB_REG_W-1:0] set_2;
    logic [PIEB_REG_W-1:0] set_3;
    logic [PIEB_REG_W-1:0] uart_levels;
    logic [PIEB_REG_W-1:0] flags_1;
    logic [PIEB_REG_W-1:0] flags_2;
    logic [PIEB_REG_W-1:0] flags_3;
    logic [PIEB_REG_W-1:0] serial_two_levels;
    logic [PIEB_REG_W-1:0] wr_flags;
    logic wr_fl_1;
    logic wr_fl_2;
    logic wr_fl_3;
    logic commit;
    logic [PIEB_ADDR_W-1:0] wa;
    logic [PIEB_ADDR_W-1:0] ra;

    // ****************************************
    // Event vectors
    // ****************************************
    always_comb begin
        set_1 = '0;
        set_1[PIEB_BIT_TIMER_ONE_GATE] = timer_one_gate_flag_set;
        set_1[PIEB_BIT_TIMER_TWO] = timer_two_match_flag_set;
        set_1[PIEB_BIT_TIMER_ONE_OVF] = timer_one_overflow_flag_set;
        set_1[PIEB_BIT_CONVERTER_DONE] = converter_done_flag_set;
        set_1[PIEB_BIT_SERIAL_ONE] = serial_one_transfer_flag_set;
        set_1[PIEB_BIT_CAPTURE_ONE] = capture_unit_one_flag_set;
        uart_levels = '0;
        uart_levels[PIEB_BIT_UART_RECEIVE] = uart_receive_pending;
        uart_levels[PIEB_BIT_UART_TRANSMIT] = uart_transmit_pending;
        set_2 = '0;
        set_2[PIEB_BIT_OSC_FAIL] = oscillator_failure_flag_set;
        set_2[PIEB_BIT_COMPARATOR_TWO] = comparator_two_flag_set;
        set_2[PIEB_BIT_COMPARATOR_ONE] = comparator_one_flag_set;
        set_2[PIEB_BIT_EEPROM_DONE] = eeprom_write_done_flag_set;
        set_2[PIEB_BIT_SERIAL_ONE_COLL] = serial_one_collision_flag_set;
        set_2[PIEB_BIT_CAPTURE_TWO] = capture_unit_two_flag_set;
        set_3 = '0;
        set_3[PIEB_BIT_CAPTURE_FOUR] = capture_unit_four_flag_set;
        set_3[PIEB_BIT_CAPTURE_THREE] = capture_unit_three_flag_set;
        set_3[PIEB_BIT_TIMER_SIX] = timer_six_match_flag_set;
        set_3[PIEB_BIT_TIMER_FOUR] = timer_four_match_flag_set;
        serial_two_levels = '0;
        serial_two_levels[PIEB_BIT_S2_COLLISION] = serial_two_collision_pending;
        serial_two_levels[PIEB_BIT_S2_TRANSFER] = serial_two_transfer_pending;
    end

    // ****************************************
    // Flag banks
    // ****************************************
    pieb_flag_bank #(
        .WIDTH(PIEB_REG_W),
        .SW_MASK(PIEB_SW_MASK_FLAGS_1),
        .HW_MASK(PIEB_HW_MASK_FLAGS_1)
    ) u_flags_1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(set_1),
        .hw_level(uart_levels),
        .wr_en(wr_fl_1),
        .wr_data(wr_flags),
        .flags(flags_1)
    );

    pieb_flag_bank #(
        .WIDTH(PIEB_REG_W),
        .SW_MASK(PIEB_SW_MASK_FLAGS_2),
        .HW_MASK(PIEB_HW_MASK_NONE)
    ) u_flags_2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(set_2),
        .hw_level(PIEB_HW_MASK_NONE),
        .wr_en(wr_fl_2),
        .wr_data(wr_flags),
        .flags(flags_2)
    );

    pieb_flag_bank #(
        .WIDTH(PIEB_REG_W),
        .SW_MASK(PIEB_SW_MASK_FLAGS_3),
        .HW_MASK(PIEB_HW_MASK_NONE)
    ) u_flags_3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_pulse(set_3),
        .hw_level(PIEB_HW_MASK_NONE),
        .wr_en(wr_fl_3),
        .wr_data(wr_flags),
        .flags(flags_3)
    );

    // ****************************************
    // Write decode for flag banks
    // ****************************************
    assign commit = (st_r.wst == PIEB_WR_IDLE) && st_r.aw_got && st_r.w_got;
    assign wa = {st_r.awaddr[PIEB_ADDR_W-1:2], 2'h0};
    assign ra = {s_axi_araddr[PIEB_ADDR_W-1:2], 2'h0};
    assign wr_flags = st_r.wdata;

    always_comb begin
        wr_fl_1 = 1'b0;
        wr_fl_2 = 1'b0;
        wr_fl_3 = 1'b0;
        if (commit && st_r.wlane) begin
            if (wa == PIEB_ADDR_FLAGS_1) begin
                wr_fl_1 = 1'b1;
            end else if (wa == PIEB_ADDR_FLAGS_2) begin
                wr_fl_2 = 1'b1;
            end else if (wa == PIEB_ADDR_FLAGS_3) begin
                wr_fl_3 = 1'b1;
            end
        end
    end

    // ****************************************
    // Bus and register logic
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // Write channel: address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[PIEB_REG_W-1:0];
            st_nxt.wlane = s_axi_wstrb[0];
        end
        case (st_r.wst)
            PIEB_WR_IDLE: begin
                if (commit) begin
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got = 1'b0;
                    st_nxt.wst = PIEB_WR_RESP;
                    st_nxt.bresp = PIEB_RESP_OKAY;
                    if (wa == PIEB_ADDR_CORE_CTRL) begin
                        if (st_r.wlane) begin
                            st_nxt.core_ctrl = st_r.wdata & PIEB_MASK_CORE_CTRL;
                        end
                    end else if (wa == PIEB_ADDR_ENABLE_1) begin
                        if (st_r.wlane) begin
                            st_nxt.enable_1 = st_r.wdata & PIEB_MASK_ENABLE_1;
                        end
                    end else if (wa == PIEB_ADDR_ENABLE_2) begin
                        if (st_r.wlane) begin
                            st_nxt.enable_2 = st_r.wdata & PIEB_MASK_ENABLE_2;
                        end
                    end else if (wa == PIEB_ADDR_ENABLE_3) begin
                        if (st_r.wlane) begin
                            st_nxt.enable_3 = st_r.wdata & PIEB_MASK_ENABLE_3;
                        end
                    end else if (wa == PIEB_ADDR_SERIAL_TWO_EN) begin
                        if (st_r.wlane) begin
                            st_nxt.serial_two_irq_enable = st_r.wdata & PIEB_MASK_SERIAL_TWO_EN;
                        end
                    end else if ((wa == PIEB_ADDR_FLAGS_1) || (wa == PIEB_ADDR_FLAGS_2) ||
                                 (wa == PIEB_ADDR_FLAGS_3)) begin
                        st_nxt.bresp = PIEB_RESP_OKAY;
                    end else begin
                        st_nxt.bresp = PIEB_RESP_DECERR;
                    end
                end
            end
            PIEB_WR_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wst = PIEB_WR_IDLE;
                end
            end
            default: begin
                st_nxt.wst = PIEB_WR_IDLE;
            end
        endcase
        // Read channel
        case (st_r.rst)
            PIEB_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    st_nxt.rst = PIEB_RD_DATA;
                    st_nxt.rdata = '0;
                    st_nxt.rresp = PIEB_RESP_OKAY;
                    if (ra == PIEB_ADDR_CORE_CTRL) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = st_r.core_ctrl;
                    end else if (ra == PIEB_ADDR_ENABLE_1) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = st_r.enable_1;
                    end else if (ra == PIEB_ADDR_ENABLE_2) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = st_r.enable_2;
                    end else if (ra == PIEB_ADDR_ENABLE_3) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = st_r.enable_3;
                    end else if (ra == PIEB_ADDR_SERIAL_TWO_EN) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = st_r.serial_two_irq_enable;
                    end else if (ra == PIEB_ADDR_FLAGS_1) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = flags_1;
                    end else if (ra == PIEB_ADDR_FLAGS_2) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = flags_2;
                    end else if (ra == PIEB_ADDR_FLAGS_3) begin
                        st_nxt.rdata[PIEB_REG_W-1:0] = flags_3;
                    end else begin
                        st_nxt.rresp = PIEB_RESP_DECERR;
                    end
                end
            end
            PIEB_RD_DATA: begin
                if (s_axi_rready) begin
                    st_nxt.rst = PIEB_RD_IDLE;
                end
            end
            default: begin
                st_nxt.rst = PIEB_RD_IDLE;
            end
        endcase
        // Request to core; global gate is left to the core itself
        st_nxt.irq = st_r.core_ctrl[PIEB_BIT_PERIPH_GATE] &&
                     (|(flags_1 & st_r.enable_1) || |(flags_2 & st_r.enable_2) ||
                      |(flags_3 & st_r.enable_3) ||
                      |(serial_two_levels & st_r.serial_two_irq_enable));
        if (!aresetn) begin
            st_nxt.wst = PIEB_WR_IDLE;
            st_nxt.rst = PIEB_RD_IDLE;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.awaddr = '0;
            st_nxt.wdata = '0;
            st_nxt.wlane = 1'b0;
            st_nxt.bresp = PIEB_RESP_OKAY;
            st_nxt.rdata = '0;
            st_nxt.rresp = PIEB_RESP_OKAY;
            st_nxt.core_ctrl = PIEB_REG_RESET;
            st_nxt.enable_1 = PIEB_REG_RESET;
            st_nxt.enable_2 = PIEB_REG_RESET;
            st_nxt.enable_3 = PIEB_REG_RESET;
            st_nxt.serial_two_irq_enable = PIEB_REG_RESET;
            st_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = (st_r.wst == PIEB_WR_IDLE) && !st_r.aw_got;
    assign s_axi_wready = (st_r.wst == PIEB_WR_IDLE) && !st_r.w_got;
    assign s_axi_bvalid = (st_r.wst == PIEB_WR_RESP);
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = (st_r.rst == PIEB_RD_IDLE);
    assign s_axi_rvalid = (st_r.rst == PIEB_RD_DATA);
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign peripheral_irq_request = st_r.irq;
    assign global_irq_gate = st_r.core_ctrl[PIEB_BIT_GLOBAL_GATE];
    assign peripheral_irq_gate = st_r.core_ctrl[PIEB_BIT_PERIPH_GATE];

endmodule : pieb_irq_bank

`default_nettype wire

/* File: unused_placeholder_never.sv */
`default_nettype none
`default_nettype wire

/* File: pieb_periph_model.sv */
`default_nettype none

module pieb_periph_model
    import pieb_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Commands, one bit per flag position
    input wire logic [23:0] fire,
    // Event pulses
    output logic [23:0] ev
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Peripherals
    // ********
    // Registered copy of fire: one cycle late, and as many cycles as the command is held
    always_ff @(posedge aclk) begin
        ev <= fire;
    end
endmodule : pieb_periph_model

`default_nettype wire

/* File: pieb_irq_monitor.sv */
`default_nettype none

module pieb_irq_monitor
    import pieb_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [PIEB_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core side
    input wire logic peripheral_irq_request,
    input wire logic peripheral_irq_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ********
    // Register bus
    // ********
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // ********
    // Core side
    // ********
    a_gate_blocks: assert property (peripheral_irq_request |-> $past(peripheral_irq_gate))
        else $error("request without gate");
    a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !peripheral_irq_request)
        else $error("outputs busy after reset");
endmodule : pieb_irq_monitor

bind pieb_irq_bank pieb_irq_monitor mon_u (.*);

`default_nettype wire

/* File: tb_top.sv */
`default_nettype none

module tb_top
    import pieb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [23:0] fire = 24'h0, ev;
    logic rx = 1'b0, tx = 1'b0, s2c = 1'b0, s2t = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, ggate, pgate;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] fm [3] = '{8'hcf, 8'hf9, 8'h3a};
    int n_mismatch = 0, n_checks = 0;
    always #50 aclk = ~aclk;
    pieb_periph_model peri_u (.aclk(aclk), .fire(fire), .ev(ev));
    pieb_irq_bank dut_u (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
        .timer_one_gate_flag_set(ev[7]), .converter_done_flag_set(ev[6]), .uart_receive_pending(rx),
        .uart_transmit_pending(tx), .serial_one_transfer_flag_set(ev[3]), .capture_unit_one_flag_set(ev[2]),
        .timer_two_match_flag_set(ev[1]), .timer_one_overflow_flag_set(ev[0]), .oscillator_failure_flag_set(ev[15]),
        .comparator_two_flag_set(ev[14]), .comparator_one_flag_set(ev[13]), .eeprom_write_done_flag_set(ev[12]),
        .serial_one_collision_flag_set(ev[11]), .capture_unit_two_flag_set(ev[8]),
        .capture_unit_four_flag_set(ev[21]), .capture_unit_three_flag_set(ev[20]),
        .timer_six_match_flag_set(ev[19]), .timer_four_match_flag_set(ev[17]),
        .serial_two_collision_pending(s2c), .serial_two_transfer_pending(s2t),
        .peripheral_irq_request(irq), .global_irq_gate(ggate), .peripheral_irq_gate(pgate));
    // ********
    // Shared tasks
    // ********
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic hung(input int i);
        if (i == 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : hung
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = PIEB_RESP_OKAY,
                      input logic [3:0] s = 4'h1);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        hung(i);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = PIEB_RESP_OKAY);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        hung(i);
        chk(s_axi_rdata, {24'h0, d});
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask : rd
    task automatic irq_is(input logic v);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, v});
    endtask : irq_is
    task automatic pulse(input logic [23:0] v);
        @(posedge aclk);
        fire <= v;
        @(posedge aclk);
        fire <= 24'h0;
    endtask : pulse
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset
    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        for (int k = 0; k < 8; k++) rd(8'(4 * k), 8'h00);
        rd(8'h20, 8'h00, PIEB_RESP_DECERR);
        wr(8'h24, 8'hff, PIEB_RESP_DECERR);
        wr(PIEB_ADDR_SERIAL_TWO_EN, 8'hff);
        rd(PIEB_ADDR_SERIAL_TWO_EN, 8'h03);
        wr(PIEB_ADDR_SERIAL_TWO_EN, 8'h00, PIEB_RESP_OKAY, 4'h0);
        rd(PIEB_ADDR_SERIAL_TWO_EN, 8'h03);
        wr(PIEB_ADDR_SERIAL_TWO_EN, 8'h00);
    endtask : t_regs
    task automatic t_flags();
        pulse({8'h3a, 8'hf9, 8'hcf});
        irq_is(1'b0);
        for (int k = 0; k < 3; k++) rd(PIEB_ADDR_FLAGS_1 + 8'(4 * k), fm[k]);
        wr(PIEB_ADDR_CORE_CTRL, 8'h40);
        wr(PIEB_ADDR_ENABLE_3, 8'h02);
        irq_is(1'b1);
        for (int k = 0; k < 3; k++) wr(PIEB_ADDR_FLAGS_1 + 8'(4 * k), 8'h00);
        irq_is(1'b0);
        for (int k = 0; k < 3; k++) rd(PIEB_ADDR_FLAGS_1 + 8'(4 * k), 8'h00);
        for (int k = 0; k < 3; k++) wr(PIEB_ADDR_FLAGS_1 + 8'(4 * k), 8'hff);
        for (int k = 0; k < 3; k++) rd(PIEB_ADDR_FLAGS_1 + 8'(4 * k), fm[k]);
        for (int k = 0; k < 3; k++) wr(PIEB_ADDR_FLAGS_1 + 8'(4 * k), 8'h00);
        wr(PIEB_ADDR_ENABLE_3, 8'h00);
    endtask : t_flags
    task automatic t_irq();
        wr(PIEB_ADDR_SERIAL_TWO_EN, 8'h02);
        s2t <= 1'b1;
        irq_is(1'b0);
        s2c <= 1'b1;
        irq_is(1'b1);
        wr(PIEB_ADDR_CORE_CTRL, 8'h00);
        irq_is(1'b0);
        wr(PIEB_ADDR_CORE_CTRL, 8'hff);
        rd(PIEB_ADDR_CORE_CTRL, 8'hc0);
        chk({30'h0, ggate, pgate}, 32'h3);
        wr(PIEB_ADDR_SERIAL_TWO_EN, 8'h01);
        s2c <= 1'b0;
        irq_is(1'b1);
        s2t <= 1'b0;
        irq_is(1'b0);
    endtask : t_irq
    task automatic t_uart();
        rx <= 1'b1;
        tx <= 1'b1;
        rd(PIEB_ADDR_FLAGS_1, 8'h30);
        wr(PIEB_ADDR_FLAGS_1, 8'h00);
        rd(PIEB_ADDR_FLAGS_1, 8'h30);
        rx <= 1'b0;
        tx <= 1'b0;
        rd(PIEB_ADDR_FLAGS_1, 8'h00);
    endtask : t_uart
    initial begin
        do_reset();
        t_regs();
        t_flags();
        t_irq();
        t_uart();
        // Second reset with state set, to see aresetn clear it
        pulse({8'h3a, 8'hf9, 8'hcf});
        do_reset();
        t_regs();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
